// *** inc/rsw_cfg.svh ***
// Constants of the reset and watchdog controller: offsets, fields, resets, timing.
`ifndef RSW_CFG_SVH
`define RSW_CFG_SVH

// ************************************************************
// Timing
// ************************************************************
`define RSW_CLK_HZ         40000000
`define RSW_SETTLE_US      1000
`define RSW_SETTLE_CYC     ((`RSW_CLK_HZ / 1000000) * `RSW_SETTLE_US)
`define RSW_WD_EXP0        12
`define RSW_WD_EXP_STEP    3
`define RSW_WD_WARN_CYC    512
`define RSW_WD_PULSE_CYC   3'h4
`define RSW_INT_PULSE_CYC  3'h4

// ************************************************************
// Constants of the core interface
// ************************************************************
`define RSW_FETCH_ADDR     16'h8000
`define RSW_HOST_RST_CMD   8'hBB

// ************************************************************
// Register offsets
// ************************************************************
`define RSW_OFF_WD_CTRL    12'h000
`define RSW_OFF_SYS_CTRL   12'h004
`define RSW_OFF_STATUS     12'h008

// ************************************************************
// Field positions and reset values
// ************************************************************
`define RSW_WD_POR_BIT     7
`define RSW_WD_SEL_HI      5
`define RSW_WD_SEL_LO      4
`define RSW_WD_IFLAG_BIT   3
`define RSW_WD_RFLAG_BIT   2
`define RSW_WD_RESTART_BIT 0
`define RSW_SYS_ISP_BIT    0
`define RSW_WD_SEL_RST     2'h0

`endif

// *** inc/rsw_pkg.sv ***
// Types shared by the reset and watchdog controller modules.
package rsw_pkg;

    typedef enum logic [1:0] {
        ST_BROWNOUT,
        ST_SETTLE,
        ST_CPU
    } rsw_seq_e;

    typedef struct packed {
        logic [21:0] cnt;
        logic        warn;
        logic [9:0]  wcnt;
        logic        timeout;
        logic        rst_pulse;
    } rsw_wdt_s;

    typedef struct packed {
        rsw_seq_e    st;
        logic [15:0] settle;
        logic [2:0]  pcnt;
        logic        por_flag;
        logic        watchdog_reset_flag;
        logic        wd_iflag;
        logic [1:0]  sel;
        logic        isp_req;
        logic        wd_restart;
        logic        cpu_reset;
        logic        analog_reset;
        logic        osc_en;
        logic        fetch_start;
        logic [15:0] fetch_addr;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } rsw_ctl_s;

endpackage

// *** inc/rsw_wdt_if.sv ***
// Link between the reset sequencer and its watchdog counter.
`timescale 1ns/1ps
interface rsw_wdt_if;
    logic       restart;
    logic [1:0] sel;
    logic       timeout;
    logic       rst_req;
    modport ctrl (output restart, output sel, input timeout, input rst_req);
    modport wdt  (input restart, input sel, output timeout, output rst_req);
endinterface

// *** verilog/rsw_wdt.sv ***
// Watchdog counter with early-warning timeout and delayed reset request.
`timescale 1ns/1ps
`include "rsw_cfg.svh"
module rsw_wdt #(
    parameter int unsigned EXP0 = `RSW_WD_EXP0
) (
    input  wire logic sys_clk_i,
    input  wire logic reset_i,
    rsw_wdt_if.wdt    wif
);

    rsw_pkg::rsw_wdt_s s_r;
    rsw_pkg::rsw_wdt_s s_nxt;

    function automatic logic [21:0] lim_f(input logic [1:0] sel);
        lim_f = 22'((64'h1 << (EXP0 + `RSW_WD_EXP_STEP * sel)) - 64'h1);
    endfunction

    // ************************************************************
    // Counter
    // ************************************************************
    always_comb begin
        s_nxt           = s_r;
        s_nxt.timeout   = 1'b0;
        s_nxt.rst_pulse = 1'b0;
        if (wif.restart) begin
            s_nxt.cnt  = 22'h0;
            s_nxt.warn = 1'b0;
            s_nxt.wcnt = 10'h0;
        end else if (s_r.warn) begin
            if (s_r.wcnt == 10'(`RSW_WD_WARN_CYC - 1)) begin
                s_nxt.rst_pulse = 1'b1;
                s_nxt.warn      = 1'b0;
                s_nxt.wcnt      = 10'h0;
            end else begin
                s_nxt.wcnt = s_r.wcnt + 10'h1;
            end
        end else if (s_r.cnt >= lim_f(wif.sel)) begin
            s_nxt.timeout = 1'b1;
            s_nxt.warn    = 1'b1;
            s_nxt.cnt     = 22'h0;
        end else begin
            s_nxt.cnt = s_r.cnt + 22'h1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign wif.timeout = s_r.timeout;
    assign wif.rst_req = s_r.rst_pulse;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    property p_wd_restart;
        wif.restart |=> s_r.cnt == 22'h0 && !s_r.warn && !wif.timeout && !wif.rst_req;
    endproperty
    a_wd_restart: assert property (p_wd_restart) else $error("restart did not clear");

    property p_wd_timeout;
        !wif.restart && !s_r.warn && s_r.cnt == lim_f(wif.sel) |=> wif.timeout;
    endproperty
    a_wd_timeout: assert property (p_wd_timeout) else $error("timeout missed");

    property p_wd_warn;
        s_r.warn && s_r.wcnt == 10'h1FF && !wif.restart |=> wif.rst_req;
    endproperty
    a_wd_warn: assert property (p_wd_warn) else $error("reset after warning missed");

    property p_wd_cause;
        wif.rst_req |-> $past(s_r.warn) && !s_r.warn;
    endproperty
    a_wd_cause: assert property (p_wd_cause) else $error("reset without warning");

endmodule // rsw_wdt

// *** verilog/rsw_reset_ctrl.sv ***
// System reset sequencer with watchdog, cause flags and APB registers.
// What this block does
// - Power-on reset puts everything in reset.
// - Power-on reset sets cause flag bit 7.
// - After power-on, fetch starts at 8000h.
// - Low supply asserts reset for its duration.
// - Settle wait before running; brownout aborts.
// - Start in brownout state; detector stays active.
// - Brownout reset equals power-on reset.
// - Interval field bits 5:4 picks timeout.
// - Timeout interrupts, reset 512 cycles later.
// - Watchdog reset pulse lasts four cycles.
// - Watchdog reset sets its cause flag.
// - Unrestarted watchdog resets the processor.
// - After watchdog reset fetch at 8000h.
// - Reset pin low holds reset; resume 8000h.
// - Pin reset leaves analog outputs alone.
// - Host command BBh gives pin-like reset.
// - Programming-done request bit forces internal reset.
// - Internal reset leaves analog outputs alone.
// - Oscillator enabled about 1ms after recovery.
`timescale 1ns/1ps
`include "rsw_cfg.svh"
module rsw_reset_ctrl #(
    parameter int unsigned SETTLE_CYCLES = `RSW_SETTLE_CYC,
    parameter int unsigned WD_EXP0       = `RSW_WD_EXP0
) (
    input  wire  logic        sys_clk_i,
    input  wire  logic        reset_i,
    input  wire  logic        supply_low_i,
    input  wire  logic        ext_rst_n_i,
    input  wire  logic        host_cmd_valid_i,
    input  wire  logic [7:0]  host_cmd_i,
    input  wire  logic [11:0] paddr_i,
    input  wire  logic        psel_i,
    input  wire  logic        penable_i,
    input  wire  logic        pwrite_i,
    input  wire  logic [31:0] pwdata_i,
    output logic       [31:0] prdata_o,
    output logic              pready_o,
    output logic              pslverr_o,
    output logic              cpu_reset_o,
    output logic              analog_reset_o,
    output logic              osc_enable_o,
    output logic              fetch_start_o,
    output logic       [15:0] fetch_addr_o,
    output logic              wd_irq_o
);

    localparam rsw_pkg::rsw_ctl_s CTL_RST = '{
        st:           rsw_pkg::ST_BROWNOUT,
        sel:          `RSW_WD_SEL_RST,
        por_flag:     1'b1,
        cpu_reset:    1'b1,
        analog_reset: 1'b1,
        fetch_addr:   `RSW_FETCH_ADDR,
        default:      '0
    };

    rsw_pkg::rsw_ctl_s r_r;
    rsw_pkg::rsw_ctl_s r_nxt;

    rsw_wdt_if wif ();

    logic apb_setup;
    logic apb_wr;
    logic host_rst;

    function automatic logic hit_f(input logic [11:0] a);
        hit_f = (a == `RSW_OFF_WD_CTRL) || (a == `RSW_OFF_SYS_CTRL) ||
                (a == `RSW_OFF_STATUS);
    endfunction

    // ************************************************************
    // Watchdog counter
    // ************************************************************
    assign wif.restart = r_r.wd_restart | r_r.cpu_reset;
    assign wif.sel     = r_r.sel;

    rsw_wdt #(
        .EXP0      (WD_EXP0)
    ) u_wdt (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .wif       (wif.wdt)
    );

    // ************************************************************
    // Bus decode
    // ************************************************************
    assign apb_setup = psel_i & ~penable_i;
    assign apb_wr    = psel_i & penable_i & r_r.pready & pwrite_i;
    assign host_rst  = host_cmd_valid_i && (host_cmd_i == `RSW_HOST_RST_CMD);

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        r_nxt             = r_r;
        r_nxt.fetch_start = 1'b0;
        r_nxt.wd_restart  = 1'b0;
        r_nxt.fetch_addr  = `RSW_FETCH_ADDR;

        // The slave answers in the first access cycle, never later.
        r_nxt.pready  = apb_setup;
        r_nxt.pslverr = apb_setup & ~hit_f(paddr_i);
        if (apb_setup) begin
            r_nxt.prdata = 32'h0;
            if (paddr_i == `RSW_OFF_WD_CTRL) begin
                r_nxt.prdata[`RSW_WD_POR_BIT]                 = r_r.por_flag;
                r_nxt.prdata[`RSW_WD_SEL_HI:`RSW_WD_SEL_LO]   = r_r.sel;
                r_nxt.prdata[`RSW_WD_IFLAG_BIT]               = r_r.wd_iflag;
                r_nxt.prdata[`RSW_WD_RFLAG_BIT]               = r_r.watchdog_reset_flag;
            end else if (paddr_i == `RSW_OFF_SYS_CTRL) begin
                r_nxt.prdata[`RSW_SYS_ISP_BIT] = r_r.isp_req;
            end else if (paddr_i == `RSW_OFF_STATUS) begin
                r_nxt.prdata[4:0] = {r_r.st, r_r.osc_en, r_r.analog_reset,
                                     r_r.cpu_reset};
            end
        end

        // Flags clear on a written one; the hardware set below wins.
        if (apb_wr && paddr_i == `RSW_OFF_WD_CTRL) begin
            r_nxt.sel = pwdata_i[`RSW_WD_SEL_HI:`RSW_WD_SEL_LO];
            r_nxt.wd_restart = pwdata_i[`RSW_WD_RESTART_BIT];
            if (pwdata_i[`RSW_WD_POR_BIT]) begin
                r_nxt.por_flag = 1'b0;
            end
            if (pwdata_i[`RSW_WD_IFLAG_BIT]) begin
                r_nxt.wd_iflag = 1'b0;
            end
            if (pwdata_i[`RSW_WD_RFLAG_BIT]) begin
                r_nxt.watchdog_reset_flag = 1'b0;
            end
        end
        if (apb_wr && paddr_i == `RSW_OFF_SYS_CTRL && pwdata_i[`RSW_SYS_ISP_BIT]) begin
            r_nxt.isp_req = 1'b1;
        end

        if (wif.timeout) begin
            r_nxt.wd_iflag = 1'b1;
        end

        // Supply sequencer; a low supply overrides every state.
        case (r_r.st)
            rsw_pkg::ST_BROWNOUT: begin
                r_nxt.settle = 16'h0;
                if (!supply_low_i) begin
                    r_nxt.st = rsw_pkg::ST_SETTLE;
                end
            end
            rsw_pkg::ST_SETTLE: begin
                if (r_r.settle == 16'(SETTLE_CYCLES - 1)) begin
                    r_nxt.st = rsw_pkg::ST_CPU;
                end else begin
                    r_nxt.settle = r_r.settle + 16'h1;
                end
            end
            rsw_pkg::ST_CPU: begin
                r_nxt.settle = 16'h0;
            end
            default: begin
                r_nxt.st = rsw_pkg::ST_BROWNOUT;
            end
        endcase
        if (supply_low_i) begin
            r_nxt.st = rsw_pkg::ST_BROWNOUT;
        end

        // Short reset pulses from the watchdog, the host and programming.
        if (wif.rst_req && r_r.st == rsw_pkg::ST_CPU) begin
            r_nxt.pcnt = `RSW_WD_PULSE_CYC;
            r_nxt.watchdog_reset_flag = 1'b1;
        end else if (host_rst || r_r.isp_req) begin
            r_nxt.pcnt    = `RSW_INT_PULSE_CYC;
            r_nxt.isp_req = 1'b0;
        end else if (r_r.pcnt != 3'h0) begin
            r_nxt.pcnt = r_r.pcnt - 3'h1;
        end

        // A power event is a full power-on reset of all state.
        if (r_nxt.st == rsw_pkg::ST_BROWNOUT) begin
            r_nxt.por_flag = 1'b1;
            r_nxt.watchdog_reset_flag     = 1'b0;
            r_nxt.wd_iflag = 1'b0;
            r_nxt.pcnt     = 3'h0;
        end

        r_nxt.cpu_reset = (r_nxt.st != rsw_pkg::ST_CPU) || (r_nxt.pcnt != 3'h0) ||
                          !ext_rst_n_i;
        // Only power events reach the analog outputs.
        r_nxt.analog_reset = (r_nxt.st != rsw_pkg::ST_CPU);
        r_nxt.osc_en       = (r_nxt.st == rsw_pkg::ST_CPU);
        r_nxt.fetch_start  = r_r.cpu_reset & ~r_nxt.cpu_reset;

        // Core-side registers return to their reset values during reset.
        if (r_r.cpu_reset) begin
            r_nxt.sel     = `RSW_WD_SEL_RST;
            r_nxt.isp_req = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            r_r <= CTL_RST;
        end else begin
            r_r <= r_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign prdata_o       = r_r.prdata;
    assign pready_o       = r_r.pready;
    assign pslverr_o      = r_r.pslverr;
    assign cpu_reset_o    = r_r.cpu_reset;
    assign analog_reset_o = r_r.analog_reset;
    assign osc_enable_o   = r_r.osc_en;
    assign fetch_start_o  = r_r.fetch_start;
    assign fetch_addr_o   = r_r.fetch_addr;
    assign wd_irq_o       = r_r.wd_iflag;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    logic run_ok;
    assign run_ok = (r_r.st == rsw_pkg::ST_CPU) && !supply_low_i && !cpu_reset_o;

    property p_power_up;
        @(posedge sys_clk_i) disable iff (1'b0)
        reset_i |=> r_r.st == rsw_pkg::ST_BROWNOUT && cpu_reset_o && analog_reset_o;
    endproperty
    a_power_up: assert property (p_power_up) else $error("bad power-up state");

    property p_por_flag;
        r_r.st == rsw_pkg::ST_BROWNOUT |-> r_r.por_flag && !r_r.watchdog_reset_flag && !wd_irq_o;
    endproperty
    a_por_flag: assert property (p_por_flag) else $error("power flags wrong");

    property p_bo_hold;
        supply_low_i |=> r_r.st == rsw_pkg::ST_BROWNOUT && cpu_reset_o && !osc_enable_o;
    endproperty
    a_bo_hold: assert property (p_bo_hold) else $error("brownout not held");

    sequence s_settle_done;
        r_r.st == rsw_pkg::ST_SETTLE && r_r.settle == 16'(SETTLE_CYCLES - 1) &&
        !supply_low_i;
    endsequence

    property p_settle;
        s_settle_done |=> r_r.st == rsw_pkg::ST_CPU && osc_enable_o && !analog_reset_o;
    endproperty
    a_settle: assert property (p_settle) else $error("settle end missed");

    property p_settle_abort;
        r_r.st == rsw_pkg::ST_SETTLE && supply_low_i |=> r_r.st == rsw_pkg::ST_BROWNOUT;
    endproperty
    a_settle_abort: assert property (p_settle_abort) else $error("abort missed");

    property p_fetch;
        fetch_start_o |-> fetch_addr_o == `RSW_FETCH_ADDR && $past(cpu_reset_o) &&
                          !cpu_reset_o;
    endproperty
    a_fetch: assert property (p_fetch) else $error("bad restart fetch");

    sequence s_wd_fire;
        wif.rst_req && r_r.st == rsw_pkg::ST_CPU && !supply_low_i;
    endsequence

    property p_wd_pulse;
        s_wd_fire |=> (cpu_reset_o && r_r.watchdog_reset_flag)[*4] ##1 r_r.pcnt == 3'h0;
    endproperty
    a_wd_pulse: assert property (p_wd_pulse) else $error("bad watchdog pulse");

    property p_ext;
        !ext_rst_n_i && r_r.st == rsw_pkg::ST_CPU && !supply_low_i |=>
            cpu_reset_o && !analog_reset_o;
    endproperty
    a_ext: assert property (p_ext) else $error("pin reset wrong");

    property p_host;
        host_rst && run_ok |=> (cpu_reset_o && !analog_reset_o)[*4];
    endproperty
    a_host: assert property (p_host) else $error("host reset wrong");

    property p_isp;
        apb_wr && paddr_i == `RSW_OFF_SYS_CTRL && pwdata_i[`RSW_SYS_ISP_BIT] && run_ok
            |=> r_r.isp_req ##1 cpu_reset_o;
    endproperty
    a_isp: assert property (p_isp) else $error("programming reset missed");

    property p_irq;
        wif.timeout && r_r.st == rsw_pkg::ST_CPU && !supply_low_i |=> wd_irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("watchdog flag missed");

    property p_sel;
        apb_wr && paddr_i == `RSW_OFF_WD_CTRL && !cpu_reset_o |=>
            wif.sel == $past(pwdata_i[5:4]);
    endproperty
    a_sel: assert property (p_sel) else $error("interval not stored");

endmodule // rsw_reset_ctrl

// *** tb/rsw_far_model.sv ***
// Far-side model: supply monitor, external reset pin and host command source.
`timescale 1ns/1ps
module rsw_far_model (
    input  wire logic       sys_clk_i,
    input  wire logic       brown_req_i,
    input  wire logic       pin_req_i,
    input  wire logic       cmd_req_i,
    input  wire logic [7:0] cmd_byte_i,
    output logic            supply_low_o,
    output logic            ext_rst_n_o,
    output logic            host_cmd_valid_o,
    output logic      [7:0] host_cmd_o
);
    initial begin
        supply_low_o     = 1'b0;
        ext_rst_n_o      = 1'b1;
        host_cmd_valid_o = 1'b0;
        host_cmd_o       = 8'h00;
    end

    always @(posedge sys_clk_i) begin
        supply_low_o     <= brown_req_i;
        ext_rst_n_o      <= ~pin_req_i;
        host_cmd_valid_o <= cmd_req_i;
        // The byte toggles outside the strobe, so a stale byte is never taken as a command.
        host_cmd_o       <= cmd_req_i ? cmd_byte_i : ~host_cmd_o;
    end
endmodule // rsw_far_model

// *** tb/system_reset_watchdog_controller_bench.sv ***
// Self-checking bench of the reset and watchdog controller.
`timescale 1ns/1ps
`include "rsw_cfg.svh"
module system_reset_watchdog_controller_bench;
    // Short counts keep the run small; the settle and interval expectations are derived from them.
    localparam int SETTLE = 20;
    localparam int EXP0   = 4;
    logic        sys_clk_i, reset_i, brown_req, pin_req, cmd_req;
    logic [7:0]  cmd_byte, host_cmd;
    logic        supply_low, ext_rst_n, host_cmd_valid;
    logic [11:0] paddr;
    logic        psel, penable, pwrite, pready, pslverr, er;
    logic [31:0] pwdata, prdata, rd;
    logic        cpu_reset, analog_reset, osc_enable, fetch_start, wd_irq;
    logic [15:0] fetch_addr;
    int          err_count, checked, seed, n, model_wd, s0, s, lim;

    rsw_far_model u_rsw_far_model (.sys_clk_i(sys_clk_i), .brown_req_i(brown_req),
        .pin_req_i(pin_req), .cmd_req_i(cmd_req), .cmd_byte_i(cmd_byte),
        .supply_low_o(supply_low), .ext_rst_n_o(ext_rst_n),
        .host_cmd_valid_o(host_cmd_valid), .host_cmd_o(host_cmd));

    rsw_reset_ctrl #(.SETTLE_CYCLES(SETTLE), .WD_EXP0(EXP0)) u_rsw_reset_ctrl (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .supply_low_i(supply_low),
        .ext_rst_n_i(ext_rst_n), .host_cmd_valid_i(host_cmd_valid), .host_cmd_i(host_cmd),
        .paddr_i(paddr), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .cpu_reset_o(cpu_reset), .analog_reset_o(analog_reset), .osc_enable_o(osc_enable),
        .fetch_start_o(fetch_start), .fetch_addr_o(fetch_addr), .wd_irq_o(wd_irq));

    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task results;
        $display("checked %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // The request is held until the rising edge at which pready is sampled high.
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge sys_clk_i);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk_i);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge sys_clk_i);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            check("apb timeout", 0, 1);
            results();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task wait_sig(input int which, input logic v, output int cnt);
        cnt = 0;
        do begin
            @(negedge sys_clk_i);
            cnt++;
        end while ((which ? wd_irq : cpu_reset) !== v && cnt < 10000);
        if (cnt >= 10000) begin
            check("wait timeout", 0, 1);
            results();
        end
    endtask

    task pulse(input string what, input int lo, input int hi, input logic ana);
        int c;
        if (cpu_reset !== 1'b1) wait_sig(0, 1'b1, c);
        check({what, " analog"}, analog_reset, ana);
        wait_sig(0, 1'b0, c);
        check({what, " length"}, (c >= lo && c <= hi), 1);
        check({what, " fetch"}, fetch_start, 1);
        check({what, " addr"}, fetch_addr, `RSW_FETCH_ADDR);
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        seed = 99379;
        err_count = 0;
        checked = 0;
        reset_i = 1'b1;
        brown_req = 1'b0;
        pin_req = 1'b0;
        cmd_req = 1'b0;
        cmd_byte = 8'h00;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (4) @(posedge sys_clk_i);
        check("por cpu", cpu_reset, 1);
        check("por analog", analog_reset, 1);
        check("por osc", osc_enable, 0);
        reset_i <= 1'b0;
        pulse("power up", SETTLE, SETTLE + 4, 1'b1);
        check("osc run", osc_enable, 1);
        model_wd = 32'h80;
        apb(1'b0, `RSW_OFF_WD_CTRL, 32'h0);
        check("wd ctrl por", rd & 32'hBC, model_wd);
        apb(1'b1, `RSW_OFF_WD_CTRL, 32'h81);
        // Restarts interleaved with refused accesses keep the shortest interval from expiring.
        for (int i = 0; i < 6; i++) begin
            apb(i[0], 12'hFFC, $random(seed));
            check("unmapped err", er, 1);
            check("unmapped data", rd & {32{~i[0]}}, 0);
            apb(1'b1, `RSW_OFF_WD_CTRL, 32'h1);
        end
        check("kicked irq", wd_irq, 0);
        s0 = $random(seed) & 3;
        for (int i = 0; i < 4; i++) begin
            s = (s0 + i) % 4;
            lim = 1 << (EXP0 + 3 * s);
            apb(1'b1, `RSW_OFF_WD_CTRL, (s << 4) | 32'h8D);
            wait_sig(1, 1'b1, n);
            check("irq delay", (n >= lim - 3 && n <= lim + 3), 1);
            wait_sig(0, 1'b1, n);
            check("reset delay", (n >= 510 && n <= 514), 1);
            pulse("wdt", 4, 4, 1'b0);
            model_wd = 32'h04;
            apb(1'b0, `RSW_OFF_WD_CTRL, 32'h0);
            check("wd flag", rd & 32'hB4, model_wd);
        end
        apb(1'b1, `RSW_OFF_WD_CTRL, 32'h20);
        fork
            pulse("brownout", 22 + SETTLE, 26 + SETTLE, 1'b1);
            begin
                brown_req <= 1'b1;
                repeat (6) @(posedge sys_clk_i);
                brown_req <= 1'b0;
                repeat (10) @(posedge sys_clk_i);
                brown_req <= 1'b1;
                repeat (6) @(posedge sys_clk_i);
                brown_req <= 1'b0;
            end
        join
        model_wd = 32'h80;
        apb(1'b0, `RSW_OFF_WD_CTRL, 32'h0);
        check("wd ctrl brownout", rd & 32'hBC, model_wd);
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, `RSW_OFF_WD_CTRL, 32'hBD);
            case (k)
                0: fork
                    pulse("pin", 10, 10, 1'b0);
                    begin
                        pin_req <= 1'b1;
                        repeat (10) @(posedge sys_clk_i);
                        pin_req <= 1'b0;
                    end
                join
                1: begin
                    cmd_byte <= $random(seed) & 8'h7F;
                    cmd_req  <= 1'b1;
                    @(posedge sys_clk_i);
                    cmd_req  <= 1'b0;
                    repeat (6) @(posedge sys_clk_i);
                    check("other cmd", cpu_reset, 0);
                    cmd_byte <= `RSW_HOST_RST_CMD;
                    cmd_req  <= 1'b1;
                    @(posedge sys_clk_i);
                    cmd_req  <= 1'b0;
                    pulse("host", 4, 4, 1'b0);
                end
                default: begin
                    apb(1'b1, `RSW_OFF_SYS_CTRL, 32'h1);
                    pulse("isp", 4, 4, 1'b0);
                end
            endcase
        end
        apb(1'b1, `RSW_OFF_STATUS, 32'hFFFF_FFFF);
        apb(1'b0, `RSW_OFF_STATUS, 32'h0);
        check("status", rd & 32'h1F, 32'h14);
        results();
    end
endmodule // system_reset_watchdog_controller_bench
